/* dac_ctrl_pkg.sv */
package dac_ctrl_pkg;

  // channel count and command layout
  localparam int         NUM_CH        = 4;
  localparam int         CH_SEL_W      = 2;
  localparam int         CMD_W         = 24;
  localparam logic [3:0] CH_ADDR_LIMIT = 4'h4;

  // command opcodes handled by this block
  localparam logic [3:0] OP_PWR_DOWN_CH   = 4'h4;
  localparam logic [3:0] OP_PWR_DOWN_CHIP = 4'h5;
  localparam logic [3:0] OP_CONFIG        = 4'h7;
  localparam logic [3:0] OP_UPDATE_ALL    = 4'h9;

  // configuration data field positions
  localparam int CFG_REF_DIS_POS   = 0;
  localparam int CFG_THERM_DIS_POS = 1;

  // reset values
  localparam logic              RST_REF_DISABLE = 1'h0;
  localparam logic              RST_THERM_DIS   = 1'h0;
  localparam logic              RST_REF_ON      = 1'h1;
  localparam logic [NUM_CH-1:0] RST_CH_ON       = 4'hF;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic [3:0]  opcode;
    logic [3:0]  addr;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic [NUM_CH-1:0] ch_powered;
    logic              ref_powered;
    logic              use_internal_ref;
    logic              thermal_protect_disable_bit;
    logic              shutdown;
  } power_status_t;

endpackage

/* level_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_value,
  output logic      [WIDTH-1:0] sync_out
);
  import dac_ctrl_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("level_sync needs WIDTH of at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second; nothing else looks at it
  always_comb begin
    next_st.first  = async_in;
    next_st.second = st.first;
    if (!rst_n) begin
      next_st.first  = rst_value;
      next_st.second = rst_value;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign sync_out = st.second;

endmodule

`default_nettype wire

/* dac_load_ref_thermal_ctrl.sv */
// Function
// - strobe high and load low copies input registers to DAC registers.
// - a load pulse inside a frame powers up outputs without updating.
// - load still low at the strobe rise runs the 24-bit word, then updates.
// - a falling load input powers up every channel, strobe regardless.
// - load low at the strobe rise cancels power-down and config words.
// - the internal reference is used only while ref-disable is 0.
// - ref-disable resets to 0 and is written by config opcode 0111b.
// - over-temperature downs channels, pulls alert low, keeps reference.
// - thermal shutdown is latched beyond the over-temperature level.
// - once cool, an update-all word, a load fall or a toggle clears the shutdown.
// - a strobe rising edge releases the alert unless a new shutdown starts in that cycle.
// - the protect-disable bit keeps over-temperature from acting.
// - 0100b powers down one channel, 0101b all channels and reference.
// - opcode 1001b updates all DAC registers like a load pulse.
`timescale 1ns/1ps
`default_nettype none

module dac_load_ref_thermal_ctrl (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        async_load_n,
  input  wire logic                        select_load_strobe_n,
  input  wire logic                        cmd_valid,
  input  wire dac_ctrl_pkg::cmd_t          cmd_word,
  input  wire logic                        toggle_update,
  input  wire logic                        overtemp_in,
  input  wire logic                        overtemp_alert_n_in,
  output logic                             cmd_exec,
  output dac_ctrl_pkg::cmd_t               cmd_exec_word,
  output logic                             dac_update,
  output dac_ctrl_pkg::power_status_t      status,
  output logic                             overtemp_alert_n_out,
  output logic                             overtemp_alert_n_oe_n
);
  import dac_ctrl_pkg::*;

  typedef struct packed {
    logic              load_d;
    logic              strobe_d;
    logic [NUM_CH-1:0] ch_on;
    logic              ref_on;
    logic              ref_disable;
    logic              therm_dis;
    logic              shutdown;
    logic              alert;
    logic              exec;
    cmd_t              exec_word;
    logic              update_pend;
    logic              update;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic [1:0] sync_q;
  logic       load_s;
  logic       ot_s;
  logic       strobe_rise;
  logic       load_low;
  logic       load_fall;
  logic       cmd_taken;
  logic       cmd_update;
  logic       upd_evt;
  logic       suppressible;
  logic       therm_fault;

  // both asynchronous levels pass two flops before any use
  level_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .async_in  ({async_load_n, overtemp_in}),
    .rst_value (2'h2),
    .sync_out  (sync_q)
  );

  assign load_s = sync_q[1];
  assign ot_s   = sync_q[0];

  // event decode; load levels synchronised, strobe taken raw against its registered copy
  assign strobe_rise  = select_load_strobe_n & ~st.strobe_d;
  assign load_low     = ~load_s;
  assign load_fall    = st.load_d & ~load_s;
  assign cmd_taken    = strobe_rise & cmd_valid;
  assign cmd_update = cmd_taken & (cmd_word.opcode == OP_UPDATE_ALL);
  assign suppressible = (cmd_word.opcode == OP_PWR_DOWN_CH)
                      | (cmd_word.opcode == OP_PWR_DOWN_CHIP)
                      | (cmd_word.opcode == OP_CONFIG);
  // a load fall, update-all word or toggle powers up and may end a thermal shutdown
  assign upd_evt      = load_fall | cmd_update | toggle_update;
  assign therm_fault  = ot_s & ~st.therm_dis;

  // next-state logic; power-ups are applied after power-downs
  always_comb begin
    next_st             = st;
    next_st.load_d      = load_s;
    next_st.strobe_d    = select_load_strobe_n;
    next_st.exec        = 1'h0;
    next_st.update_pend = 1'h0;
    if (cmd_taken) begin
      next_st.exec_word = cmd_word;
      // a late load kills power-down and config words
      next_st.exec = ~(load_low & suppressible);
      // late load: run the command now, update one cycle later
      next_st.update_pend = load_low;
      if (!load_low) begin
        if (cmd_word.opcode == OP_PWR_DOWN_CH &&
            cmd_word.addr < CH_ADDR_LIMIT) begin
          next_st.ch_on[cmd_word.addr[CH_SEL_W-1:0]] = 1'h0;
        end
        if (cmd_word.opcode == OP_PWR_DOWN_CHIP) begin
          next_st.ch_on  = '0;
          next_st.ref_on = 1'h0;
        end
        if (cmd_word.opcode == OP_CONFIG) begin
          next_st.ref_disable = cmd_word.data[CFG_REF_DIS_POS];
          next_st.therm_dis   = cmd_word.data[CFG_THERM_DIS_POS];
        end
      end
    end
    // load falling edge powers up regardless of the strobe
    if (upd_evt) begin
      next_st.ch_on  = '1;
      next_st.ref_on = 1'h1;
    end
    // strobe high and load low: copy every cycle the level lasts
    next_st.update = (select_load_strobe_n & load_low)
                   | st.update_pend
                   | cmd_update;
    // shutdown latches; an update clears it only once cool
    next_st.shutdown = therm_fault
                     | (st.shutdown & ~upd_evt)
                     | (st.shutdown & ot_s);
    // strobe rise releases the alert, a new shutdown sets it again
    if (strobe_rise) begin
      next_st.alert = 1'h0;
    end
    if (therm_fault & ~st.shutdown) begin
      next_st.alert = 1'h1;
    end
    if (!rst_n) begin
      next_st.load_d      = 1'h1;
      next_st.strobe_d    = 1'h1;
      next_st.ch_on       = RST_CH_ON;
      next_st.ref_on      = RST_REF_ON;
      next_st.ref_disable = RST_REF_DISABLE;
      next_st.therm_dis   = RST_THERM_DIS;
      next_st.shutdown    = 1'h0;
      next_st.alert       = 1'h0;
      next_st.exec        = 1'h0;
      next_st.exec_word   = '0;
      next_st.update_pend = 1'h0;
      next_st.update      = 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // outputs; the reference stays on through a thermal shutdown
  assign cmd_exec                = st.exec;
  assign cmd_exec_word           = st.exec_word;
  assign dac_update              = st.update;
  assign status.ch_powered       =
    st.ch_on & ~{NUM_CH{st.shutdown & ~st.therm_dis}};
  assign status.ref_powered      = st.ref_on;
  assign status.use_internal_ref = ~st.ref_disable;
  assign status.thermal_protect_disable_bit = st.therm_dis;
  assign status.shutdown         = st.shutdown;
  // open drain: the pad only ever pulls low
  assign overtemp_alert_n_out    = 1'h0;
  assign overtemp_alert_n_oe_n   = ~st.alert;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_late_load;
    cmd_taken && load_low && !suppressible;
  endsequence

  sequence s_exec_then_update;
    cmd_exec ##1 dac_update;
  endsequence

  a_load_copy_level: assert property (
    select_load_strobe_n && load_low |=> dac_update
  ) else $error("load low with strobe high did not update");

  a_pulse_no_update: assert property (
    !select_load_strobe_n && !st.update_pend |=> !dac_update
  ) else $error("update while strobe low");

  a_late_load_exec: assert property (
    s_late_load |=> s_exec_then_update
  ) else $error("late load did not execute then update");

  a_load_fall_powerup: assert property (
    load_fall |=> (&st.ch_on) && st.ref_on
  ) else $error("load fall did not power up");

  a_late_load_inhibit: assert property (
    cmd_taken && load_low && suppressible |=> !cmd_exec && st.ref_on
  ) else $error("inhibited command took effect");

  a_config_ref_select: assert property (
    cmd_taken && !load_low && cmd_word.opcode == OP_CONFIG
    |=> status.use_internal_ref != $past(cmd_word.data[CFG_REF_DIS_POS])
  ) else $error("reference select not written by config");

  a_fault_shutdown: assert property (
    therm_fault && !cmd_taken |=> status.ch_powered == '0 &&
    status.ref_powered >= $past(status.ref_powered)
  ) else $error("over-temperature did not power down");

  a_alert_on_fault: assert property (
    therm_fault && !st.shutdown |=> !overtemp_alert_n_oe_n
                                    && !overtemp_alert_n_in
  ) else $error("alert not driven low on shutdown");

  a_shutdown_latched: assert property (
    st.shutdown && !upd_evt |=> st.shutdown
  ) else $error("shutdown cleared without update");

  a_update_clears: assert property (
    st.shutdown && upd_evt && !ot_s |=> !st.shutdown
  ) else $error("cool update did not clear shutdown");

  a_hot_update_holds: assert property (
    upd_evt && therm_fault |=> st.shutdown ##0 status.ch_powered == '0
  ) else $error("hot update restored channels");

  a_strobe_release: assert property (
    strobe_rise && !(therm_fault && !st.shutdown) |=> overtemp_alert_n_oe_n
  ) else $error("strobe rise did not release alert");

  a_protect_disable: assert property (
    st.therm_dis |-> status.ch_powered == st.ch_on
  ) else $error("disabled protection still powered down");

  a_pd_channel: assert property (
    cmd_taken && !load_low && !upd_evt && cmd_word.opcode == OP_PWR_DOWN_CH
    && cmd_word.addr == 4'h1 |=> !st.ch_on[1]
  ) else $error("channel power-down missed");

  a_update_cmd: assert property (
    cmd_update |=> dac_update && (&st.ch_on)
  ) else $error("update command did not update");

endmodule

`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic          core_clk,
  input  wire logic          alert_out,
  input  wire logic          alert_oe_n,
  output logic               alert_pad,
  output logic               load_n,
  output logic               strobe_n,
  output logic               valid,
  output dac_ctrl_pkg::cmd_t word
);
  import dac_ctrl_pkg::*;

  // the alert line has a pull-up, so a released pad reads high
  assign alert_pad = alert_oe_n ? 1'b1 : alert_out;

  initial begin
    load_n   = 1'b1;
    strobe_n = 1'b1;
    valid    = 1'b0;
    word     = '0;
  end

  // one framed word; ld pulls the load pin low and leaves it low after the frame
  task automatic xfer(input cmd_t w, input logic ld);
    @(negedge core_clk);
    strobe_n = 1'b0;
    word     = w;
    if (ld) begin
      load_n = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    valid = 1'b1;
    @(negedge core_clk);
    strobe_n = 1'b1;
    @(negedge core_clk);
    valid = 1'b0;
    word  = ~w; // stale bits must not look valid
  endtask

  task automatic set_load(input logic v);
    @(negedge core_clk);
    load_n = v;
  endtask

  // frame without a word: strobe only, valid stays low
  task automatic set_strobe(input logic v);
    @(negedge core_clk);
    strobe_n = v;
  endtask
endmodule

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import dac_ctrl_pkg::*;

  logic          core_clk;
  logic          rst_n;
  logic          toggle_update;
  logic          overtemp_in;
  logic          load_n;
  logic          strobe_n;
  logic          valid;
  cmd_t          word;
  logic          pad;
  logic          cmd_exec;
  cmd_t          exec_word;
  logic          dac_update;
  power_status_t status;
  logic          alert_out;
  logic          alert_oe_n;
  int            fails;
  int            checked;

  dac_load_ref_thermal_ctrl dac_load_ref_thermal_ctrl_i (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .async_load_n         (load_n),
    .select_load_strobe_n (strobe_n),
    .cmd_valid            (valid),
    .cmd_word             (word),
    .toggle_update        (toggle_update),
    .overtemp_in          (overtemp_in),
    .overtemp_alert_n_in  (pad),
    .cmd_exec             (cmd_exec),
    .cmd_exec_word        (exec_word),
    .dac_update           (dac_update),
    .status               (status),
    .overtemp_alert_n_out (alert_out),
    .overtemp_alert_n_oe_n(alert_oe_n)
  );

  host_model host_model_i (
    .core_clk  (core_clk),
    .alert_out (alert_out),
    .alert_oe_n(alert_oe_n),
    .alert_pad (pad),
    .load_n    (load_n),
    .strobe_n  (strobe_n),
    .valid     (valid),
    .word      (word)
  );

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic pulse_toggle();
    @(negedge core_clk);
    toggle_update = 1'b1;
    @(negedge core_clk);
    toggle_update = 1'b0;
  endtask

  // power-down commands, then load pin and update-all restore
  task automatic t_power();
    host_model_i.xfer(24'h500000, 1'b0);
    chk(4'(cmd_exec), 4'h1);
    wt(1);
    chk(status.ch_powered, 4'h0);
    chk(4'(status.ref_powered), 4'h0);
    host_model_i.set_load(1'b0);
    wt(4);
    chk(status.ch_powered, 4'hF);
    chk(4'(dac_update), 4'h1);
    host_model_i.set_load(1'b1);
    host_model_i.xfer(24'h410000, 1'b0);
    chk(exec_word.opcode, 4'h4);
    chk(exec_word.addr, 4'h1);
    wt(1);
    chk(status.ch_powered, 4'hD);
    host_model_i.xfer(24'h440000, 1'b0);
    wt(1);
    chk(status.ch_powered, 4'hD);
    host_model_i.xfer(24'h900000, 1'b0);
    chk(4'(dac_update), 4'h1);
    wt(1);
    chk(status.ch_powered, 4'hF);
    $display("t_power done");
  endtask

  // load pulse inside a frame powers up but never updates
  task automatic t_pulse();
    host_model_i.xfer(24'h500000, 1'b0);
    wt(1);
    chk(status.ch_powered, 4'h0);
    host_model_i.set_strobe(1'b0);
    host_model_i.set_load(1'b0);
    wt(3);
    chk(status.ch_powered, 4'hF);
    chk(4'(status.ref_powered), 4'h1);
    chk(4'(dac_update), 4'h0);
    host_model_i.set_load(1'b1);
    wt(3);
    host_model_i.set_strobe(1'b1);
    wt(1);
    chk(4'(dac_update), 4'h0);
    chk(4'(cmd_exec), 4'h0);
    $display("t_pulse done");
  endtask

  // host selects the external reference, then a late load cancels config
  task automatic t_cfg();
    host_model_i.xfer(24'h700001, 1'b0);
    wt(1);
    chk(4'(status.use_internal_ref), 4'h0);
    host_model_i.xfer(24'h700000, 1'b1);
    chk(4'(cmd_exec), 4'h0);
    wt(2);
    chk(4'(dac_update), 4'h1);
    chk(4'(status.use_internal_ref), 4'h0);
    host_model_i.xfer(24'hF00000, 1'b1);
    chk(4'(cmd_exec), 4'h1);
    chk(exec_word.opcode, 4'hF);
    wt(1);
    chk(4'(dac_update), 4'h1);
    host_model_i.set_load(1'b1);
    wt(4);
    $display("t_cfg done");
  endtask

  // latched shutdown, alert release, refused and accepted clears
  task automatic t_therm();
    overtemp_in = 1'b1;
    wt(4);
    chk(4'(status.shutdown), 4'h1);
    chk(4'(pad), 4'h0);
    chk(status.ch_powered, 4'h0);
    chk(4'(status.ref_powered), 4'h1);
    pulse_toggle();
    wt(1);
    chk(4'(status.shutdown), 4'h1);
    host_model_i.xfer(24'hF00000, 1'b0);
    wt(1);
    chk(4'(pad), 4'h1);
    overtemp_in = 1'b0;
    wt(4);
    chk(status.ch_powered, 4'h0);
    pulse_toggle();
    wt(1);
    chk(4'(status.shutdown), 4'h0);
    chk(status.ch_powered, 4'hF);
    host_model_i.xfer(24'h700003, 1'b0);
    chk(4'(status.thermal_protect_disable_bit), 4'h1);
    overtemp_in = 1'b1;
    wt(4);
    chk(status.ch_powered, 4'hF);
    overtemp_in = 1'b0;
    $display("t_therm done");
  endtask

  // hang guard, far beyond the 138 cycles the tests need
  initial begin
    #50000;
    fails++;
    stop_test();
  end

  initial begin
    core_clk      = 1'b0;
    rst_n         = 1'b0;
    toggle_update = 1'b0;
    overtemp_in   = 1'b0;
    fails         = 0;
    checked       = 0;
    wt(16);
    chk(status.ch_powered, 4'hF);
    chk(4'(status.use_internal_ref), 4'h1);
    chk(4'(status.thermal_protect_disable_bit), 4'h0);
    chk(4'(alert_oe_n), 4'h1);
    rst_n = 1'b1;
    wt(2);
    t_power();
    t_pulse();
    t_cfg();
    t_therm();
    stop_test();
  end
endmodule

`default_nettype wire
